/* dv/sim_host_model.sv */
// Purpose: host controller model driving the discrete connector input pins
// Assumes: levels change just after a rising clock edge
// Notes: the bench calls drive to move the pins
`timescale 1ns/1ps
module sim_host_model (
    input  wire logic       clk_i,
    output logic            alarm_reset_o,
    output logic            servo_on_o,
    output logic [2:0]      sel_pins_o,
    output logic            forced_stop_o,
    output logic            sub_mode_o,
    output logic            ext_cmd_o
);
    initial begin
        alarm_reset_o = 1'b0;
        servo_on_o    = 1'b0;
        sel_pins_o    = 3'h0;
        forced_stop_o = 1'b1;
        sub_mode_o    = 1'b0;
        ext_cmd_o     = 1'b0;
    end
    task automatic drive(input logic servo_on_input, input logic [2:0] p, input logic em,
                         input logic sub, input logic cmd, input logic res);
        @(posedge clk_i);
        servo_on_o    <= servo_on_input;
        sel_pins_o    <= p;
        forced_stop_o <= em;
        sub_mode_o    <= sub;
        ext_cmd_o     <= cmd;
        alarm_reset_o <= res;
    endtask : drive
endmodule : sim_host_model

/* dv/sim_io_map_test.sv */
// Purpose: self-checking bench for the io map, forcing and jog block
// Assumes: slave answers a cycle after the request, outputs a cycle behind pins
// Notes: positioning test locks the block, so it runs last
`timescale 1ns/1ps
`include "sim_defines.svh"
module sim_io_map_test;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [3:0] sel = 4'h0;
    logic ack, res, servo_on_input, em, sub, cmd, up = 1'b0, dn = 1'b0, brk, ccw, cw, jstop;
    logic [2:0] pins;
    logic [4:0] sout = 5'h15, pout;
    logic [12:0] led;
    logic [15:0] jspd, jacc;
    sim_pkg::sim_logic_in_t lin;
    int failures = 0, checks = 0, cycles = 0;

    sim_host_model i_sim_host_model (.clk_i(clk_i), .alarm_reset_o(res),
        .servo_on_o(servo_on_input), .sel_pins_o(pins), .forced_stop_o(em), .sub_mode_o(sub),
        .ext_cmd_o(cmd));
    sim_io_map i_sim_io_map (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .alarm_reset_input_i(res), .servo_on_input_i(servo_on_input),
        .sel_pins_i(pins), .forced_stop_input_i(em), .sub_mode_i(sub),
        .ext_cmd_active_i(cmd), .btn_up_i(up), .btn_down_i(dn), .servo_out_i(sout),
        .pin_out_o(pout), .brake_release_o(brk), .led_seg_o(led), .logic_in_o(lin),
        .jog_ccw_o(ccw), .jog_cw_o(cw), .jog_stop_o(jstop), .jog_speed_o(jspd),
        .jog_accel_o(jacc));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic state(input logic [2:0] k);
        tick(3);
        wb(1'b0, `SIM_ADR_STATUS, 32'h0);
        check("test state", {29'h0, rd[2:0]}, {29'h0, k});
    endtask : state

    // 0 position, 1 speed, 2 torque, 3 positioning
    function automatic sim_pkg::sim_logic_in_t map_exp(input int m, input int s,
                                                       input logic [2:0] p, input logic a);
        sim_pkg::sim_logic_in_t e;
        int k;
        e = '0;
        k = (m == 0) ? 0 : (m == 1) ? s : (m == 2) ? 1 : (m == 3) ? 1 + s :
            (m == 4) ? 2 : (m == 5) ? (s ? 0 : 2) : 3;
        case (k)
            0: {e.clear_input, e.forward_stroke_end, e.reverse_stroke_end} = {p[0], p[1] | a, p[2] | a};
            1: {e.speed_select_bit1, e.forward_start_input, e.reverse_start_input} = {p[0], p[1], p[2]};
            2: {e.speed_select_bit1, e.reverse_rotation_select, e.forward_rotation_select} = {p[0], p[1], p[2]};
            default: {e.table_select_bit1, e.forward_start_input, e.reverse_start_input} = {p[0], p[1], p[2]};
        endcase
        return e;
    endfunction : map_exp

    initial begin
        tick(16);
        rst_i <= 1'b0;
        wb(1'b0, `SIM_ADR_JOGSPD, 32'h0);
        check("jog speed reg", rd, 32'h000000c8);
        check("jog speed out", {16'h0, jspd}, 32'h000000c8);
        wb(1'b1, `SIM_ADR_JOGACC, 32'h0000c351);
        wb(1'b0, `SIM_ADR_JOGACC, 32'h0);
        check("jog accel reg", rd, 32'h000003e8);
        wb(1'b1, `SIM_ADR_JOGACC, 32'h0000c350);
        tick(2);
        check("jog accel out", {16'h0, jacc}, 32'h0000c350);
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped read", rd, 32'h0);
        $display("test registers done");
        for (int m = 0; m < 7; m++)
            for (int s = 0; s < 2; s++)
                for (int p = 2; p < 6; p += 3) begin
                    i_sim_host_model.drive(1'b0, 3'(p), 1'b1, 1'(s), 1'b0, 1'(s));
                    wb(1'b1, `SIM_ADR_MODE, 32'(m));
                    tick(3);
                    check("pin map", 32'(lin), 32'(map_exp(m, s, 3'(p), 1'b0)));
                    check("leds", 32'(led), {21'h0, sout, 1'b1, 3'(p), 1'b0, 1'(s)});
                end
        wb(1'b1, `SIM_ADR_MODE, 32'h0);
        wb(1'b1, `SIM_ADR_MODE, 32'h7);
        wb(1'b0, `SIM_ADR_MODE, 32'h0);
        check("mode refused", rd, 32'h0);
        wb(1'b1, `SIM_ADR_TEST, 32'h80);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(3);
        check("auto on map", 32'(lin), 32'(map_exp(0, 0, 3'h0, 1'b1)));
        $display("test mapping done");
        wb(1'b1, `SIM_ADR_FORCE, 32'h08);
        wb(1'b1, `SIM_ADR_TEST, 32'h01);
        tick(3);
        check("forced pins", 32'(pout), 32'h08);
        check("brake release", 32'(brk), 32'h1);
        i_sim_host_model.drive(1'b1, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(3);
        check("force with servo on", 32'(pout), 32'h15);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        wb(1'b1, `SIM_ADR_TEST, 32'h0);
        tick(3);
        check("force released", 32'(pout), 32'h15);
        check("brake held", 32'(brk), 32'h0);
        $display("test forcing done");
        i_sim_host_model.drive(1'b1, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        wb(1'b1, `SIM_ADR_TEST, 32'h02);
        state(3'h0);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        state(3'h0);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        state(3'h1);
        up <= 1'b1;
        tick(3);
        check("jog up", {30'h0, ccw, cw}, 32'h2);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        tick(3);
        check("jog ext cmd", {30'h0, ccw, cw}, 32'h0);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        up <= 1'b0;
        dn <= 1'b1;
        tick(3);
        check("jog down", {30'h0, ccw, cw}, 32'h1);
        dn <= 1'b0;
        tick(3);
        check("jog released", {30'h0, ccw, cw}, 32'h0);
        wb(1'b1, `SIM_ADR_TEST, 32'h22);
        tick(2);
        check("link lost stop", 32'(jstop), 32'h1);
        wb(1'b1, `SIM_ADR_TEST, 32'h62);
        tick(2);
        check("link ok run", 32'(jstop), 32'h0);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        state(3'h0);
        i_sim_host_model.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        for (int k = 1; k < 4; k++) begin
            wb(1'b1, `SIM_ADR_TEST, 32'h1 << k);
            state(3'(k));
            wb(1'b1, `SIM_ADR_TEST, 32'h0);
            state(3'h0);
        end
        $display("test jog done");
        wb(1'b1, `SIM_ADR_MODE, 32'h6);
        wb(1'b1, `SIM_ADR_TEST, 32'h10);
        state(3'h4);
        wb(1'b1, `SIM_ADR_TEST, 32'h0);
        state(3'h5);
        $display("test positioning lock done");
        complete_run();
    end
endmodule : sim_io_map_test

/* src/sim_defines.svh */
// Purpose: constants for the servo io map and jog test block
// Assumes: 32-bit classic wishbone, word registers
// Notes: offsets are byte addresses
`ifndef SIM_DEFINES_SVH
`define SIM_DEFINES_SVH
`define SIM_ADR_MODE      8'h00
`define SIM_ADR_TEST      8'h04
`define SIM_ADR_FORCE     8'h08
`define SIM_ADR_JOGSPD    8'h0c
`define SIM_ADR_JOGACC    8'h10
`define SIM_ADR_STATUS    8'h14
`define SIM_ADR_LEDS      8'h18
`define SIM_JOG_SPD_RST   16'h00c8
`define SIM_JOG_ACC_RST   16'h03e8
`define SIM_JOG_ACC_MAX   16'hc350
`define SIM_CTL_FORCE_EN  0
`define SIM_CTL_JOG       1
`define SIM_CTL_MOTORLESS 2
`define SIM_CTL_TOUGH     3
`define SIM_CTL_POSTEST   4
`define SIM_CTL_SWJOG     5
`define SIM_CTL_LINK_OK   6
`define SIM_CTL_AUTO_ON   7
`endif

/* src/sim_io_map.sv */
// Purpose: connector pin mapping, pin display, forced outputs and jog gating
// Assumes: pins synchronous to clk_i; wishbone classic slave, one wait cycle
// Notes: pin bus bit k is connector input pin k+5, out bit k is output slot k
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "sim_defines.svh"

// What this block does
// - each display segment lights while its connector pin is on.
// - control mode selects position, speed, torque, change or positioning mapping.
// - pin 5 is clear, speed select 1, or table select bit 1.
// - pin 6 is forward stroke end, forward start or reverse rotation select.
// - pin 7 is reverse stroke end, reverse start or forward rotation select.
// - software can force each output on or off while servo-on input is off.
// - forcing outputs allowed only while servo-on input is off.
// - forcing brake interlock on releases the brake even with servo off.
// - no test operation starts unless servo-on input is off.
// - after positioning test, normal operation returns only after power cycling.
// - test selection offers jog, motor-less and forced tough drive.
// - stroke end inputs read permanently on when auto-on setting is set.
// - jog allowed only when no external command is being received.
// - jog rotates only while a button is held; up ccw, down cw.
// - jog speed defaults to 200 rpm, settable up to permissible speed.
// - jog accel time defaults to 1000 ms, settable 0 to 50000 ms.
// - lost software link during software jog decelerates motor to stop.
// - forced stop input stops test operation.
module sim_io_map #(
    parameter int NOUT      = 5,
    parameter int SPD_MAX   = 16'hffff
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        alarm_reset_input_i,
    input  wire logic        servo_on_input_i,
    input  wire logic [2:0]  sel_pins_i,
    input  wire logic        forced_stop_input_i,
    input  wire logic        sub_mode_i,
    input  wire logic        ext_cmd_active_i,
    input  wire logic        btn_up_i,
    input  wire logic        btn_down_i,
    input  wire logic [NOUT-1:0] servo_out_i,
    output logic [NOUT-1:0]  pin_out_o,
    output logic             brake_release_o,
    output logic [12:0]      led_seg_o,
    output sim_pkg::sim_logic_in_t logic_in_o,
    output logic             jog_ccw_o,
    output logic             jog_cw_o,
    output logic             jog_stop_o,
    output logic [15:0]      jog_speed_o,
    output logic [15:0]      jog_accel_o
);
    localparam int BRK = 3;

    // led field holds output slots [10:6] plus two spare segments
    if (NOUT < 4 || NOUT > 7) begin : g_bad_nout
        $error("NOUT must be 4..7");
    end
    // jog speed register is 16 bits wide
    if (SPD_MAX < 0 || SPD_MAX > 32'h0000ffff) begin : g_bad_spd
        $error("SPD_MAX must fit 16 bits");
    end

    sim_pkg::sim_mode_t  mode_r;
    sim_pkg::sim_test_t  test_r;
    logic [7:0]          ctl_r;
    logic [NOUT-1:0]     force_val_r;
    logic [15:0]         spd_r;
    logic [15:0]         acc_r;
    logic                ack_r;
    logic [31:0]         rdat_r;
    logic                wr;
    logic [2:0]          tsel;
    sim_pkg::sim_mode_t  eff;
    logic                strk_auto;
    sim_pkg::sim_logic_in_t li_nxt;
    logic                force_ok;
    logic [NOUT-1:0]     out_nxt;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];

    // register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r      <= sim_pkg::SIM_POS;
            ctl_r       <= 8'h00;
            force_val_r <= '0;
            spd_r       <= `SIM_JOG_SPD_RST;
            acc_r       <= `SIM_JOG_ACC_RST;
        end else if (wr) begin
            unique case (wb_adr_i)
                `SIM_ADR_MODE: begin
                    if (wb_dat_i[2:0] <= 3'h6) mode_r <= sim_pkg::sim_mode_t'(wb_dat_i[2:0]);
                end
                `SIM_ADR_TEST: ctl_r <= wb_dat_i[7:0];
                `SIM_ADR_FORCE: force_val_r <= wb_dat_i[NOUT-1:0];
                `SIM_ADR_JOGSPD: begin
                    if (wb_dat_i[15:0] <= 16'(SPD_MAX)) spd_r <= wb_dat_i[15:0];
                end
                `SIM_ADR_JOGACC: begin
                    if (wb_dat_i[15:0] <= `SIM_JOG_ACC_MAX) acc_r <= wb_dat_i[15:0];
                end
                default: ;
            endcase
        end
    end

    // test operation state
    assign tsel = {ctl_r[`SIM_CTL_TOUGH], ctl_r[`SIM_CTL_MOTORLESS], ctl_r[`SIM_CTL_JOG]};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_r <= sim_pkg::SIM_NORMAL;
        end else begin
            unique case (test_r)
                sim_pkg::SIM_NORMAL: begin
                    if (!servo_on_input_i && forced_stop_input_i) begin
                        if (ctl_r[`SIM_CTL_POSTEST] && mode_r == sim_pkg::SIM_PTAB)
                            test_r <= sim_pkg::SIM_POSTEST;
                        else if (tsel[0] && !ext_cmd_active_i)
                            test_r <= sim_pkg::SIM_JOG;
                        else if (tsel[1])
                            test_r <= sim_pkg::SIM_MOTORLESS;
                        else if (tsel[2])
                            test_r <= sim_pkg::SIM_TOUGH;
                    end
                end
                sim_pkg::SIM_JOG, sim_pkg::SIM_MOTORLESS, sim_pkg::SIM_TOUGH: begin
                    if (!forced_stop_input_i || tsel == 3'h0)
                        test_r <= sim_pkg::SIM_NORMAL;
                end
                sim_pkg::SIM_POSTEST: begin
                    if (!ctl_r[`SIM_CTL_POSTEST] || !forced_stop_input_i)
                        test_r <= sim_pkg::SIM_LOCKED;
                end
                sim_pkg::SIM_LOCKED: test_r <= sim_pkg::SIM_LOCKED;
                default: test_r <= sim_pkg::SIM_NORMAL;
            endcase
        end
    end

    // input mapping per mode
    assign strk_auto = ctl_r[`SIM_CTL_AUTO_ON];
    always_comb begin
        eff = mode_r;
        unique case (mode_r)
            sim_pkg::SIM_PS: eff = sub_mode_i ? sim_pkg::SIM_SPD : sim_pkg::SIM_POS;
            sim_pkg::SIM_ST: eff = sub_mode_i ? sim_pkg::SIM_TRQ : sim_pkg::SIM_SPD;
            sim_pkg::SIM_TP: eff = sub_mode_i ? sim_pkg::SIM_POS : sim_pkg::SIM_TRQ;
            default: eff = mode_r;
        endcase
        li_nxt = '0;
        unique case (eff)
            sim_pkg::SIM_POS: begin
                li_nxt.clear_input        = sel_pins_i[0];
                li_nxt.forward_stroke_end = sel_pins_i[1] | strk_auto;
                li_nxt.reverse_stroke_end = sel_pins_i[2] | strk_auto;
            end
            sim_pkg::SIM_SPD: begin
                li_nxt.speed_select_bit1   = sel_pins_i[0];
                li_nxt.forward_start_input = sel_pins_i[1];
                li_nxt.reverse_start_input = sel_pins_i[2];
            end
            sim_pkg::SIM_TRQ: begin
                li_nxt.speed_select_bit1       = sel_pins_i[0];
                li_nxt.reverse_rotation_select = sel_pins_i[1];
                li_nxt.forward_rotation_select = sel_pins_i[2];
            end
            default: begin
                li_nxt.table_select_bit1   = sel_pins_i[0];
                li_nxt.forward_start_input = sel_pins_i[1];
                li_nxt.reverse_start_input = sel_pins_i[2];
            end
        endcase
    end

    // forced outputs
    assign force_ok = ctl_r[`SIM_CTL_FORCE_EN] && !servo_on_input_i;
    assign out_nxt  = force_ok ? force_val_r : servo_out_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o       <= '0;
            brake_release_o <= 1'b0;
            logic_in_o      <= '0;
            led_seg_o       <= 13'h0000;
        end else begin
            pin_out_o       <= out_nxt;
            brake_release_o <= out_nxt[BRK];
            logic_in_o      <= li_nxt;
            led_seg_o       <= 13'({out_nxt, forced_stop_input_i, sel_pins_i,
                                    servo_on_input_i, alarm_reset_input_i});
        end
    end

    // jog drive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jog_ccw_o   <= 1'b0;
            jog_cw_o    <= 1'b0;
            jog_stop_o  <= 1'b0;
            jog_speed_o <= `SIM_JOG_SPD_RST;
            jog_accel_o <= `SIM_JOG_ACC_RST;
        end else begin
            jog_speed_o <= spd_r;
            jog_accel_o <= acc_r;
            if (test_r == sim_pkg::SIM_JOG && forced_stop_input_i && !ext_cmd_active_i) begin
                jog_ccw_o  <= btn_up_i && !btn_down_i;
                jog_cw_o   <= btn_down_i && !btn_up_i;
                jog_stop_o <= ctl_r[`SIM_CTL_SWJOG] && !ctl_r[`SIM_CTL_LINK_OK];
            end else begin
                jog_ccw_o  <= 1'b0;
                jog_cw_o   <= 1'b0;
                jog_stop_o <= 1'b0;
            end
        end
    end

    // bus read and ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
            unique case (wb_adr_i)
                `SIM_ADR_MODE:   rdat_r <= {29'h0, mode_r};
                `SIM_ADR_TEST:   rdat_r <= {24'h0, ctl_r};
                `SIM_ADR_FORCE:  rdat_r <= {{(32-NOUT){1'b0}}, force_val_r};
                `SIM_ADR_JOGSPD: rdat_r <= {16'h0, spd_r};
                `SIM_ADR_JOGACC: rdat_r <= {16'h0, acc_r};
                `SIM_ADR_STATUS: rdat_r <= {27'h0, force_ok, 1'b0, test_r};
                `SIM_ADR_LEDS:   rdat_r <= {19'h0, led_seg_o};
                default:         rdat_r <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // assertions
    property p_jog_gate;
        @(posedge clk_i) disable iff (rst_i)
        (jog_ccw_o || jog_cw_o) |-> $past(test_r == sim_pkg::SIM_JOG && forced_stop_input_i);
    endproperty
    a_jog_gate: assert property (p_jog_gate) else $error("jog without jog test");

    property p_no_test_son;
        @(posedge clk_i) disable iff (rst_i)
        (test_r == sim_pkg::SIM_NORMAL && servo_on_input_i) |=> test_r == sim_pkg::SIM_NORMAL;
    endproperty
    a_no_test_son: assert property (p_no_test_son) else $error("test entered with servo on");

    property p_locked;
        @(posedge clk_i) disable iff (rst_i)
        test_r == sim_pkg::SIM_LOCKED |=> test_r == sim_pkg::SIM_LOCKED;
    endproperty
    a_locked: assert property (p_locked) else $error("left lock without reset");

    property p_estop;
        @(posedge clk_i) disable iff (rst_i)
        (test_r == sim_pkg::SIM_JOG && !forced_stop_input_i) |=> test_r == sim_pkg::SIM_NORMAL;
    endproperty
    a_estop: assert property (p_estop) else $error("forced stop ignored");

    property p_force;
        @(posedge clk_i) disable iff (rst_i)
        force_ok |=> pin_out_o == $past(force_val_r);
    endproperty
    a_force: assert property (p_force) else $error("forced value not driven");

    property p_force_son;
        @(posedge clk_i) disable iff (rst_i)
        servo_on_input_i |=> pin_out_o == $past(servo_out_i);
    endproperty
    a_force_son: assert property (p_force_son) else $error("forced while servo on");

    property p_brake;
        @(posedge clk_i) disable iff (rst_i)
        ##1 brake_release_o == pin_out_o[BRK];
    endproperty
    a_brake: assert property (p_brake) else $error("brake not following output");

    property p_led;
        @(posedge clk_i) disable iff (rst_i)
        ##1 led_seg_o[1] == $past(servo_on_input_i);
    endproperty
    a_led: assert property (p_led) else $error("servo-on segment wrong");

    property p_dir;
        @(posedge clk_i) disable iff (rst_i)
        !(jog_ccw_o && jog_cw_o);
    endproperty
    a_dir: assert property (p_dir) else $error("both jog directions");

    property p_auto;
        @(posedge clk_i) disable iff (rst_i)
        (strk_auto && mode_r == sim_pkg::SIM_POS) |=> logic_in_o.forward_stroke_end;
    endproperty
    a_auto: assert property (p_auto) else $error("auto-on stroke end low");

    property p_estop_entry;
        @(posedge clk_i) disable iff (rst_i)
        (test_r == sim_pkg::SIM_NORMAL && !forced_stop_input_i) |=> test_r == sim_pkg::SIM_NORMAL;
    endproperty
    a_estop_entry: assert property (p_estop_entry) else $error("test entered in stop");

    property p_jog_ext;
        @(posedge clk_i) disable iff (rst_i)
        (test_r == sim_pkg::SIM_JOG && ext_cmd_active_i) |=> !(jog_ccw_o || jog_cw_o);
    endproperty
    a_jog_ext: assert property (p_jog_ext) else $error("jog during external command");

    property p_release;
        @(posedge clk_i) disable iff (rst_i)
        !force_ok |=> pin_out_o == $past(servo_out_i);
    endproperty
    a_release: assert property (p_release) else $error("forced state not released");

    property p_led_res;
        @(posedge clk_i) disable iff (rst_i)
        ##1 led_seg_o[0] == $past(alarm_reset_input_i);
    endproperty
    a_led_res: assert property (p_led_res) else $error("reset segment wrong");

    property p_spd_max;
        @(posedge clk_i) disable iff (rst_i)
        jog_speed_o <= 16'(SPD_MAX);
    endproperty
    a_spd_max: assert property (p_spd_max) else $error("jog speed above limit");

    property p_acc_max;
        @(posedge clk_i) disable iff (rst_i)
        jog_accel_o <= `SIM_JOG_ACC_MAX;
    endproperty
    a_acc_max: assert property (p_acc_max) else $error("jog accel above limit");

    c_jog:  cover property (@(posedge clk_i) jog_ccw_o ##[1:20] jog_cw_o);
    c_lock: cover property (@(posedge clk_i) test_r == sim_pkg::SIM_LOCKED);
    c_frc:  cover property (@(posedge clk_i) force_ok && brake_release_o);
    c_stop: cover property (@(posedge clk_i)
        test_r == sim_pkg::SIM_JOG ##1 test_r == sim_pkg::SIM_NORMAL);
    c_mtl:  cover property (@(posedge clk_i) test_r == sim_pkg::SIM_MOTORLESS);
endmodule : sim_io_map

/* src/sim_pkg.sv */
// Purpose: types for the servo io map and jog test block
// Assumes: nothing
// Notes: mode codes follow the mode table order
package sim_pkg;
    typedef enum logic [2:0] {
        SIM_POS   = 3'h0,
        SIM_PS    = 3'h1,
        SIM_SPD   = 3'h2,
        SIM_ST    = 3'h3,
        SIM_TRQ   = 3'h4,
        SIM_TP    = 3'h5,
        SIM_PTAB  = 3'h6
    } sim_mode_t;
    typedef enum logic [2:0] {
        SIM_NORMAL    = 3'h0,
        SIM_JOG       = 3'h1,
        SIM_MOTORLESS = 3'h2,
        SIM_TOUGH     = 3'h3,
        SIM_POSTEST   = 3'h4,
        SIM_LOCKED    = 3'h5
    } sim_test_t;
    typedef struct packed {
        logic clear_input;
        logic speed_select_bit1;
        logic table_select_bit1;
        logic forward_stroke_end;
        logic reverse_stroke_end;
        logic forward_start_input;
        logic reverse_start_input;
        logic forward_rotation_select;
        logic reverse_rotation_select;
    } sim_logic_in_t;
endpackage : sim_pkg
